/* hdl/ilr_regs.sv */
// Contract
// - read-only 8-bit temperature register at 0Eh, zero after reset
// - lock set: writes to all other writable bits are ignored
// - lock set: only key bits in the lock register accept writes
// - lock bit clears only on device reset
// - lock set: error code computed continuously and compared to reference
// - lock set: self-test disabled and further requests refused
// - SPI, report on: silent until timer expires, then one error response
// - SPI, report on: supply errors clear on status read only at timer zero
// - SPI, report off: silent while timer nonzero, auto-clear at zero
// - I2C: silent until timer expires, status read clears supply errors
// - soft reset needs three ordered writes: keys 00, 11, 10
// - write answers carry the new value including written key bits
// - third key write starts reset, no response, no I2C acknowledge
// - lock register reads return 00 key bits and abort any key sequence; other reads leave it
// - key bits left out of the error-detection code
// - error-code mismatch sets array error flag bit 5 of status two
//
// Purpose: init-lock, supply-report control and soft-restart key register bank
// Assumes: serial front end delivers one decoded access per req.valid pulse
// Notes:   other writable registers live elsewhere and obey cfgWriteOk
`timescale 1ns/1ps
`default_nettype none
module ilr_regs (
   // clock and reset
   input  wire  logic                 sys_clk,
   input  wire  logic                 arst_n,
   // register access
   input  wire  ilr_pkg::ilr_req_type req,
   output var   ilr_pkg::ilr_rsp_type rsp,
   output var   logic                 noAck,
   // sensing and mode
   input  wire  logic [7:0]           tempSample,
   input  wire  logic                 tempUpdate,
   input  wire  logic                 i2cMode,
   input  wire  logic                 supTimerZero,
   input  wire  logic                 supFault,
   input  wire  logic                 statusTxSup,
   input  wire  logic [7:0]           userRegImage,
   input  wire  logic                 selfTestReq,
   // control out
   output var   logic                 cfgWriteOk,
   output var   logic                 selfTestGo,
   output var   logic                 softReset,
   output var   logic                 supErrFlag,
   output var   logic                 sendErrCode,
   output var   logic                 rwArrayErr,
   output var   logic                 lockActive
);

   // ****************************************
   // state
   // ****************************************
   logic [7:0]          tempReg;
   logic [7:0]          lockReg;
   ilr_pkg::ilr_key_type keyState;
   ilr_pkg::ilr_key_type next_keyState;
   logic                timerWasZero;
   logic                errPending;
   logic                edcMismatch;
   logic                isWr;
   logic                isRd;
   logic                lockWr;
   logic                lockRd;
   logic                stat1Rd;
   logic                stat2Rd;
   logic [1:0]          keyIn;
   logic                keyFire;

   assign isWr    = req.valid && req.write;
   assign isRd    = req.valid && !req.write;
   assign lockWr  = isWr && (req.addr == ilr_pkg::ADDR_LOCK);
   assign lockRd  = isRd && (req.addr == ilr_pkg::ADDR_LOCK);
   assign stat1Rd = isRd && (req.addr == ilr_pkg::ADDR_STAT1);
   assign stat2Rd = isRd && (req.addr == ilr_pkg::ADDR_STAT2);
   assign keyIn   = req.data[1:0];
   assign keyFire = lockWr && (keyState == ilr_pkg::ILR_KEY_GOT2) && (keyIn == ilr_pkg::KEY_STEP3);

   // ****************************************
   // temperature
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tempReg <= ilr_pkg::RESET_VALUE;
      end else if (tempUpdate) begin
         tempReg <= tempSample;
      end
   end

   // ****************************************
   // lock register
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lockReg <= ilr_pkg::RESET_VALUE;
      end else if (lockWr && !lockReg[ilr_pkg::BIT_LOCK]) begin
         // once locked the stored bits freeze; lock itself only ever rises
         lockReg <= req.data & ilr_pkg::MASK_STORED;
      end
   end

   assign lockActive = lockReg[ilr_pkg::BIT_LOCK];

   // ****************************************
   // key sequence
   // ****************************************
   always_comb begin
      next_keyState = keyState;
      if (lockRd) begin
         next_keyState = ilr_pkg::ILR_KEY_IDLE;
      end else if (lockWr) begin
         unique case (keyState)
            ilr_pkg::ILR_KEY_GOT1: begin
               next_keyState = (keyIn == ilr_pkg::KEY_STEP2) ? ilr_pkg::ILR_KEY_GOT2 :
                               (keyIn == ilr_pkg::KEY_STEP1) ? ilr_pkg::ILR_KEY_GOT1 : ilr_pkg::ILR_KEY_IDLE;
            end
            ilr_pkg::ILR_KEY_GOT2: begin
               next_keyState = (keyIn == ilr_pkg::KEY_STEP1) ? ilr_pkg::ILR_KEY_GOT1 : ilr_pkg::ILR_KEY_IDLE;
            end
            default: begin
               next_keyState = (keyIn == ilr_pkg::KEY_STEP1) ? ilr_pkg::ILR_KEY_GOT1 : ilr_pkg::ILR_KEY_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         keyState <= ilr_pkg::ILR_KEY_IDLE;
      end else begin
         keyState <= next_keyState;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         softReset <= 1'b0;
         noAck     <= 1'b0;
      end else begin
         softReset <= keyFire;
         noAck     <= keyFire && i2cMode;
      end
   end

   // ****************************************
   // access answers
   // ****************************************
   function automatic logic [7:0] readMux(input logic [7:0] a);
      unique case (a)
         ilr_pkg::ADDR_TEMP: readMux = tempReg;
         ilr_pkg::ADDR_LOCK: readMux = lockReg; // key bits read back as 00
         // status two shows only the array error flag here; its other bits live elsewhere
         ilr_pkg::ADDR_STAT2: readMux = 8'(rwArrayErr) << ilr_pkg::BIT_RWERR;
         default:            readMux = 8'h00;
      endcase
   endfunction

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp <= '0;
      end else begin
         rsp.valid  <= req.valid;
         // supply lockout keeps the bus quiet until the monitor timer ends
         rsp.silent <= keyFire || (req.valid && !supTimerZero);
         if (lockWr) begin
            rsp.data <= (lockReg[ilr_pkg::BIT_LOCK] ? lockReg : (req.data & ilr_pkg::MASK_STORED))
                        | {6'h00, keyIn};
         end else if (isRd) begin
            rsp.data <= readMux(req.addr);
         end else begin
            rsp.data <= 8'h00;
         end
      end
   end

   // ****************************************
   // lock consequences
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgWriteOk <= 1'b1;
         selfTestGo <= 1'b0;
      end else begin
         cfgWriteOk <= !lockActive && !(lockWr && req.data[ilr_pkg::BIT_LOCK]);
         selfTestGo <= selfTestReq && !lockActive;
      end
   end

   ilr_edc u_edc (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .enable   (lockActive),
      .guarded  (userRegImage ^ (lockReg & ilr_pkg::MASK_STORED)),
      .mismatch (edcMismatch)
   );

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rwArrayErr <= 1'b0;
      end else if (edcMismatch) begin
         rwArrayErr <= 1'b1;
      end else if (stat2Rd) begin
         rwArrayErr <= 1'b0;
      end
   end

   // ****************************************
   // supply error reporting
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         timerWasZero <= 1'b1;
      end else begin
         timerWasZero <= supTimerZero;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         supErrFlag <= 1'b0;
      end else if (supFault) begin
         supErrFlag <= 1'b1;
      end else if (supTimerZero) begin
         if (!i2cMode && lockReg[ilr_pkg::BIT_SUPOFF]) begin
            supErrFlag <= 1'b0;
         end else if (stat1Rd || (!i2cMode && statusTxSup)) begin
            supErrFlag <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         errPending  <= 1'b0;
         sendErrCode <= 1'b0;
      end else begin
         if (supTimerZero && !timerWasZero && !i2cMode && !lockReg[ilr_pkg::BIT_SUPOFF]) begin
            errPending <= 1'b1;
         end else if (req.valid && errPending) begin
            errPending <= 1'b0;
         end
         sendErrCode <= req.valid && errPending && supTimerZero;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_lock_sticky: assert property (@(posedge sys_clk) disable iff (!arst_n)
      lockActive |=> lockActive) else $error("lock bit dropped");
   a_lock_freeze: assert property (@(posedge sys_clk) disable iff (!arst_n)
      lockActive |=> $stable(lockReg)) else $error("locked register changed");
   a_cfg_blocked: assert property (@(posedge sys_clk) disable iff (!arst_n)
      lockActive |=> !cfgWriteOk) else $error("writes allowed while locked");
   a_selftest_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
      lockActive |=> !selfTestGo) else $error("self-test while locked");
   a_temp_ro: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !tempUpdate |=> $stable(tempReg)) else $error("temperature changed without sample");
   a_read_key_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
      lockRd |=> rsp.data[1:0] == 2'h0 && keyState == ilr_pkg::ILR_KEY_IDLE) else $error("read leaked key");
   // one idle slot between key writes matches the host's access pacing
   sequence s_key_step1;
      lockWr && keyIn == ilr_pkg::KEY_STEP1;
   endsequence
   sequence s_key_step2;
      lockWr && keyIn == ilr_pkg::KEY_STEP2;
   endsequence
   sequence s_key_step3;
      lockWr && keyIn == ilr_pkg::KEY_STEP3;
   endsequence
   sequence s_key12;
      s_key_step1 ##1 !req.valid ##1 s_key_step2;
   endsequence
   a_key_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_key12 ##1 !req.valid ##1 s_key_step3 |=> softReset && rsp.silent)
      else $error("key sequence missed");
   // back-to-back key writes are legal as well
   a_key_b2b: assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_key_step1 ##1 s_key_step2 ##1 s_key_step3 |=> softReset && rsp.silent)
      else $error("back-to-back key sequence missed");
   a_key_restart: assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_key_step1 |=> keyState == ilr_pkg::ILR_KEY_GOT1) else $error("00 key write not taken as step one");
   a_write_echo: assert property (@(posedge sys_clk) disable iff (!arst_n)
      lockWr && !keyFire |=> rsp.data[1:0] == $past(keyIn)) else $error("write echo lacks key");
   a_array_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
      edcMismatch |=> rwArrayErr) else $error("array error not flagged");
   a_status_two: assert property (@(posedge sys_clk) disable iff (!arst_n)
      stat2Rd |=> rsp.data[ilr_pkg::BIT_RWERR] == $past(rwArrayErr)) else $error("status two flag not shown");
   a_supply_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
      req.valid && !supTimerZero |=> rsp.silent) else $error("answered during supply lockout");

   // answer pacing, restart side effects and supply reporting
   a_rsp_timing: assert property (@(posedge sys_clk) disable iff (!arst_n)
      req.valid |=> rsp.valid) else $error("access left unanswered");
   a_noack_i2c: assert property (@(posedge sys_clk) disable iff (!arst_n)
      softReset |-> rsp.silent && noAck == $past(i2cMode)) else $error("restart frame or acknowledge wrong");
   a_err_once: assert property (@(posedge sys_clk) disable iff (!arst_n)
      sendErrCode |=> !sendErrCode) else $error("error code sent twice");
   // a fault in the same cycle keeps the flag set, so it is left out here
   a_auto_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
      supTimerZero && !i2cMode && lockReg[ilr_pkg::BIT_SUPOFF] && !supFault |=> !supErrFlag)
      else $error("supply error not auto-cleared");

endmodule
`default_nettype wire

/* hdl/ilr_pkg.sv */
// Purpose: shared constants and carriers for the init-lock / soft-restart register bank
// Assumes: 8-bit registers reached through a serial-interface register port
// Notes:   timing-free block; all counts are events, not time
package ilr_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_TEMP      = 8'h0E;
   localparam logic [7:0] ADDR_LOCK      = 8'h10;
   localparam logic [7:0] ADDR_STAT1     = 8'h02;
   localparam logic [7:0] ADDR_STAT2     = 8'h03;
   localparam logic [7:0] RESET_VALUE    = 8'h00;

   // ****************************************
   // lock register fields
   // ****************************************
   localparam int         BIT_LOCK       = 7;
   localparam int         BIT_SUPOFF     = 3;
   localparam logic [7:0] MASK_KEY       = 8'h03;
   localparam logic [7:0] MASK_STORED    = 8'hF8;
   localparam logic [7:0] MASK_SUPOFF    = 8'h08;
   localparam logic [1:0] KEY_STEP1      = 2'h0;
   localparam logic [1:0] KEY_STEP2      = 2'h3;
   localparam logic [1:0] KEY_STEP3      = 2'h2;
   localparam int         BIT_RWERR      = 5;

   typedef enum logic [1:0] {
      ILR_KEY_IDLE,
      ILR_KEY_GOT1,
      ILR_KEY_GOT2
   } ilr_key_type;

   // one register access from the serial front end
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } ilr_req_type;

   // answer to one access
   typedef struct packed {
      logic       valid;
      logic       silent;
      logic [7:0] data;
   } ilr_rsp_type;

endpackage

/* hdl/ilr_edc.sv */
// Purpose: running error-detection code over the user-writable bytes
// Assumes: code is sampled as reference on the cycle the lock becomes active
// Notes:   simple rotate-xor code; key bits are masked off by the caller
`timescale 1ns/1ps
`default_nettype none
module ilr_edc (
   // clock and reset
   input  wire  logic       sys_clk,
   input  wire  logic       arst_n,
   // control
   input  wire  logic       enable,
   input  wire  logic [7:0] guarded,
   // result
   output var   logic       mismatch
);

   logic [7:0] refCode;
   logic       armed;

   function automatic logic [7:0] edc8(input logic [7:0] v);
      edc8 = {v[6:0], v[7]} ^ v ^ 8'hA5;
   endfunction

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         refCode <= 8'h00;
         armed   <= 1'b0;
      end else if (enable && !armed) begin
         refCode <= edc8(guarded);
         armed   <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mismatch <= 1'b0;
      end else begin
         mismatch <= armed && (edc8(guarded) != refCode);
      end
   end

endmodule
`default_nettype wire

/* dv/ilr_host.sv */
// Purpose: host model issuing single accesses to the lock register bank
// Assumes: one access at a time, held until the edge that takes it
// Notes:   answer captured one cycle after the request is driven
`timescale 1ns/1ps
`default_nettype none
module ilr_host (
   // clock
   input  wire logic                 sys_clk,
   // register access
   output var  ilr_pkg::ilr_req_type req,
   input  wire ilr_pkg::ilr_rsp_type rsp,
   // events seen with the answer
   input  wire logic                 noAck,
   input  wire logic                 softReset,
   input  wire logic                 sendErrCode
);
   initial begin
      req = '0;
   end
   // released fields show inverted values so stale data is never mistaken for valid
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                         output ilr_pkg::ilr_rsp_type r, output logic [2:0] ev);
      @(posedge sys_clk);
      req <= '{valid: 1'b1, write: wr, addr: a, data: d};
      @(posedge sys_clk);
      req <= '{valid: 1'b0, write: ~wr, addr: ~a, data: ~d};
      #1;
      r  = rsp;
      ev = {noAck, softReset, sendErrCode};
   endtask
   // three ordered key writes, the last one restarts the device
   task automatic restart(output ilr_pkg::ilr_rsp_type r, output logic [2:0] ev);
      access(1'b1, ilr_pkg::ADDR_LOCK, 8'h00, r, ev);
      access(1'b1, ilr_pkg::ADDR_LOCK, 8'h03, r, ev);
      access(1'b1, ilr_pkg::ADDR_LOCK, 8'h02, r, ev);
   endtask
endmodule
`default_nettype wire

/* dv/init_lock_soft_reset_regs_tb.sv */
// Purpose: self-checking bench for the init-lock / soft-restart register bank
// Assumes: accesses spaced by one idle cycle, supply timer normally at zero
// Notes:   soft restart is followed by an external reset, as the system would do
`timescale 1ns/1ps
`default_nettype none
module init_lock_soft_reset_regs_tb;
   logic sys_clk, arst_n, noAck, tempUpdate, i2cMode, supTimerZero, supFault, statusTxSup, selfTestReq;
   logic cfgWriteOk, selfTestGo, softReset, supErrFlag, sendErrCode, rwArrayErr, lockActive;
   logic [7:0]           tempSample, userRegImage, d;
   logic [2:0]           ev;
   ilr_pkg::ilr_req_type req;
   ilr_pkg::ilr_rsp_type rsp, r;
   int                   fail_count, cmp_count, m;
   integer               seed;

   ilr_regs dut (.sys_clk(sys_clk), .arst_n(arst_n), .req(req), .rsp(rsp), .noAck(noAck),
      .tempSample(tempSample), .tempUpdate(tempUpdate), .i2cMode(i2cMode), .supTimerZero(supTimerZero),
      .supFault(supFault), .statusTxSup(statusTxSup), .userRegImage(userRegImage),
      .selfTestReq(selfTestReq), .cfgWriteOk(cfgWriteOk), .selfTestGo(selfTestGo), .softReset(softReset),
      .supErrFlag(supErrFlag), .sendErrCode(sendErrCode), .rwArrayErr(rwArrayErr), .lockActive(lockActive));
   ilr_host host (.sys_clk(sys_clk), .req(req), .rsp(rsp), .noAck(noAck), .softReset(softReset),
      .sendErrCode(sendErrCode));

   // ****************************************
   // clock, checks and verdict
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge sys_clk);
      fail_count++;
      summarize();
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host.access(1'b1, a, v, r, ev);
   endtask
   task automatic rd(input logic [7:0] a);
      host.access(1'b0, a, 8'h00, r, ev);
   endtask
   task automatic doReset();
      @(posedge sys_clk);
      arst_n <= 1'b0;
      cyc(20);
      arst_n <= 1'b1;
   endtask
   task automatic fault();
      @(posedge sys_clk);
      supFault <= 1'b1;
      @(posedge sys_clk);
      supFault <= 1'b0;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      seed = 32'h8779E9BD;
      {arst_n, tempUpdate, i2cMode, supFault, statusTxSup, selfTestReq} = '0;
      {tempSample, userRegImage, fail_count, cmp_count} = '0;
      supTimerZero = 1'b1;
      doReset();
      chk(8'(cfgWriteOk), 8'h01, "write ok after reset");
      rd(ilr_pkg::ADDR_TEMP);
      chk(r.data, 8'h00, "temp reset");
      for (int i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         @(posedge sys_clk);
         tempSample <= d;
         tempUpdate <= 1'b1;
         @(posedge sys_clk);
         tempUpdate <= 1'b0;
         wr(ilr_pkg::ADDR_TEMP, ~d);
         rd(ilr_pkg::ADDR_TEMP);
         chk(r.data, d, "temp read only");
      end
      for (int i = 0; i < 8; i++) begin
         d = (8'($random(seed)) & 8'h78) | 8'h01;
         wr(ilr_pkg::ADDR_LOCK, d);
         chk(r.data, d, "write echo");
         chk(8'(r.valid), 8'h01, "answer valid");
         rd(ilr_pkg::ADDR_LOCK);
         chk(r.data, d & 8'h78, "key read zero");
      end
      wr(ilr_pkg::ADDR_LOCK, 8'h00);
      wr(ilr_pkg::ADDR_LOCK, 8'h03);
      rd(ilr_pkg::ADDR_LOCK);
      wr(ilr_pkg::ADDR_LOCK, 8'h02);
      chk(8'(ev[1]), 8'h00, "read aborts key");
      for (m = 0; m < 2; m++) begin
         @(posedge sys_clk);
         i2cMode <= m[0];
         wr(ilr_pkg::ADDR_LOCK, 8'h00);
         wr(ilr_pkg::ADDR_LOCK, 8'h03);
         chk(r.data, 8'h03, "key echo");
         wr(ilr_pkg::ADDR_LOCK, 8'h00);
         rd(ilr_pkg::ADDR_TEMP);
         wr(ilr_pkg::ADDR_LOCK, 8'h03);
         wr(ilr_pkg::ADDR_LOCK, 8'h02);
         chk(8'(ev[2:1]), {6'h00, m[0], 1'b1}, "restart and ack");
         chk(8'(r.silent), 8'h01, "restart silent");
         doReset();
      end
      @(posedge sys_clk);
      {i2cMode, selfTestReq} <= 2'b01;
      cyc(3);
      chk(8'(selfTestGo), 8'h01, "self-test open");
      wr(ilr_pkg::ADDR_LOCK, 8'h80);
      cyc(3);
      chk({5'h00, lockActive, cfgWriteOk, selfTestGo}, 8'h04, "lock effects");
      wr(ilr_pkg::ADDR_LOCK, 8'h0B);
      chk(r.data, 8'h83, "locked write");
      rd(ilr_pkg::ADDR_LOCK);
      chk(r.data, 8'h80, "lock kept");
      cyc(4);
      chk(8'(rwArrayErr), 8'h00, "key bits outside code");
      @(posedge sys_clk);
      userRegImage <= 8'h5A;
      cyc(4);
      chk(8'(rwArrayErr), 8'h01, "code mismatch");
      rd(ilr_pkg::ADDR_STAT2);
      chk(8'(r.data[ilr_pkg::BIT_RWERR]), 8'h01, "status two flag");
      host.restart(r, ev);
      chk(8'(ev[1]), 8'h01, "restart while locked");
      doReset();
      @(posedge sys_clk);
      {selfTestReq, supTimerZero} <= 2'b00;
      fault();
      rd(ilr_pkg::ADDR_STAT1);
      chk(8'({r.silent, supErrFlag}), 8'h03, "silent, flag kept");
      @(posedge sys_clk);
      supTimerZero <= 1'b1;
      rd(ilr_pkg::ADDR_TEMP);
      chk(8'(ev[0]), 8'h01, "error code once");
      rd(ilr_pkg::ADDR_TEMP);
      chk(8'({ev[0], supErrFlag}), 8'h01, "single error code");
      rd(ilr_pkg::ADDR_STAT1);
      cyc(1);
      chk(8'(supErrFlag), 8'h00, "status read clears");
      fault();
      @(posedge sys_clk);
      statusTxSup <= 1'b1;
      @(posedge sys_clk);
      statusTxSup <= 1'b0;
      cyc(2);
      chk(8'(supErrFlag), 8'h00, "status frame clears");
      for (m = 0; m < 2; m++) begin
         @(posedge sys_clk);
         i2cMode <= m[0];
         wr(ilr_pkg::ADDR_LOCK, 8'h09);
         @(posedge sys_clk);
         supTimerZero <= 1'b0;
         fault();
         rd(ilr_pkg::ADDR_TEMP);
         chk(8'(r.silent), 8'h01, "silent while timing");
         @(posedge sys_clk);
         supTimerZero <= 1'b1;
         cyc(3);
         chk(8'(supErrFlag), {7'h00, m[0]}, "auto clear in serial mode only");
         rd(ilr_pkg::ADDR_STAT1);
         cyc(1);
         chk({6'h00, r.silent, supErrFlag}, 8'h00, "resumed and clear");
      end
      summarize();
   end
endmodule
`default_nettype wire
